// *** verilog/mid_pkg.sv ***
// Constants shared by the measurement filter and result routing logic.
// Assumes one 100 MHz clock and a sequencer that streams channel samples.
package mid_pkg;
    // =========================================================================
    // Sizes
    localparam int NCELL = 14;
    localparam int NCH   = 15;
    localparam int DW    = 16;
    localparam int FRAC  = 3;
    localparam int AW    = DW + FRAC;
    localparam int PW    = AW + 4;
    localparam int SW    = 20;
    localparam int CHW   = 4;
    localparam int ADW   = 8;

    // =========================================================================
    // Channel map, register offsets and field values
    localparam logic [CHW-1:0] BLOCK_CH      = 4'hE;
    localparam logic [ADW-1:0] ADDR_BLOCK    = 8'h55;
    localparam logic [2:0]     COEF_RESET    = 3'h2;
    localparam logic [2:0]     COEF_OFF      = 3'h7;
    localparam logic [2:0]     COEF_BALANCE  = 3'h0;
    localparam logic [3:0]     WEIGHT_ONE    = 4'h8;
    localparam logic [AW:0]    ROUND_HALF    = 20'h0_0004;
    localparam logic [DW-1:0]  RESULT_RESET  = 16'h0000;

    // =========================================================================
    // Complete state of the block.
    typedef struct packed {
        logic [NCH-1:0][AW-1:0] acc;
        logic [NCH-1:0][DW-1:0] alu;
        logic [NCH-1:0][DW-1:0] res;
        logic [NCH-1:0][DW-1:0] alrt;
        logic [DW-1:0]          d1_alu;
        logic [DW-1:0]          d2_alu;
        logic [DW-1:0]          diag1;
        logic [DW-1:0]          diag2;
        logic [SW-1:0]          sum;
        logic [7:0]             ext;
        logic [DW-1:0]          mism;
        logic [2:0]             coef;
        logic                   init_done;
        logic                   pend;
        logic                   done;
        logic                   ready;
        logic [DW-1:0]          rd;
        logic                   rd_valid;
    } mid_state_type;
endpackage : mid_pkg

// *** verilog/mid_filter.sv ***
// Per-channel first-order IIR filter and result routing for the acquisition sequencer.
// Assumes sequencer events (scan start, scan end, move) are one-cycle pulses on i_clk_sys
// and that the host link decodes its own register writes into the strobes below.
`timescale 1ns/1ps

module mid_filter (
    input  wire logic                                   i_clk_sys,              // System clock
    input  wire logic                                   i_resetn,               // Sync reset, active low
    input  wire logic                                   i_smp_valid,            // Sample strobe
    input  wire logic [mid_pkg::CHW-1:0]                i_smp_chan,             // Sample channel
    input  wire logic [mid_pkg::DW-1:0]                 i_raw_data,             // Raw ADC result
    input  wire logic [mid_pkg::DW-1:0]                 i_cal_data,             // Calibrated result
    input  wire logic                                   i_diag_valid,           // Diag sample strobe
    input  wire logic [mid_pkg::DW-1:0]                 i_diag1_data,           // Diag 1 sample
    input  wire logic [mid_pkg::DW-1:0]                 i_diag2_data,           // Diag 2 sample
    input  wire logic                                   i_scan_start,           // Scan start pulse
    input  wire logic                                   i_scan_end,             // Scan end pulse
    input  wire logic                                   i_move_req,             // Out-of-scan move
    input  wire logic                                   i_balance_active,       // Auto balancing scan
    input  wire logic                                   i_calibration_enable,   // Use calibrated data
    input  wire logic [mid_pkg::NCH-1:0]                i_measurement_enable_1, // Channel enables
    input  wire logic                                   i_filter_amend_enable,  // Fold into filter
    input  wire logic                                   i_read_filtered_select, // Output filtered
    input  wire logic                                   i_alert_source_select,  // Alert from filtered
    input  wire logic                                   i_scan_filter_init,     // Scan init request
    input  wire logic                                   i_balance_filter_init,  // Balance init request
    input  wire logic                                   i_double_buffer_enable, // Double buffering
    input  wire logic                                   i_coef_wr,              // Coefficient write
    input  wire logic [2:0]                             i_coef_wdata,           // Coefficient code
    input  wire logic                                   i_ready_clear,          // Host clears ready
    input  wire logic                                   i_rd_en,                // Register read
    input  wire logic [mid_pkg::ADW-1:0]                i_rd_addr,              // Register address
    output logic      [mid_pkg::DW-1:0]                 o_rd_data,              // Read data
    output logic                                        o_rd_valid,             // Read data valid
    output logic      [2:0]                             o_filter_coefficient,   // Coefficient field
    output logic      [mid_pkg::NCELL*mid_pkg::DW-1:0]  o_cell_result,          // Cell results
    output logic      [mid_pkg::DW-1:0]                 o_block_voltage_result, // Block result
    output logic      [mid_pkg::NCH*mid_pkg::DW-1:0]    o_alert_data,           // Alert data
    output logic      [mid_pkg::SW-1:0]                 o_sum_result,           // Cell sum
    output logic      [7:0]                             o_extreme_cell_index,   // Max, min index
    output logic      [mid_pkg::DW-1:0]                 o_mismatch_value,       // Max minus min
    output logic      [mid_pkg::DW-1:0]                 o_diag_result_1,        // Diag 1 result
    output logic      [mid_pkg::DW-1:0]                 o_diag_result_2,        // Diag 2 result
    output logic                                        o_acquisition_done_flag, // Scan done
    output logic                                        o_result_ready_flag     // Results ready
);
    import mid_pkg::*;

    // =========================================================================
    // State and event decode
    mid_state_type           st_r;
    mid_state_type           st_nxt;
    logic [2:0]              eff_coef;
    logic                    amend_eff;
    logic                    init_req;
    logic                    move_now;
    logic                    fold_now;
    logic                    move_oos;
    logic                    move_scan;
    logic [NCH-1:0][AW-1:0]  acc_new;
    logic [NCH-1:0][DW-1:0]  rnd_old;
    logic [NCH-1:0][DW-1:0]  rnd_new;

    assign eff_coef  = (i_balance_active && st_r.coef == COEF_OFF) ? COEF_BALANCE : st_r.coef;
    assign amend_eff = i_filter_amend_enable | i_balance_active;
    assign init_req  = i_scan_filter_init | i_balance_filter_init;
    assign move_oos  = i_move_req & ~st_r.ready;
    assign move_scan = (i_scan_end & ~i_double_buffer_enable)
                     | (i_scan_start & i_double_buffer_enable & st_r.pend);
    assign move_now  = move_scan | move_oos;
    assign fold_now  = amend_eff & move_now;

    // =========================================================================
    // Filter arithmetic. The accumulator keeps three fraction bits so that
    // eighth-step weights truncate history only below one eighth; rounding happens on output.
    always_comb begin
        logic [3:0]    w;
        logic [PW-1:0] p;
        logic [AW:0]   r_old;
        logic [AW:0]   r_new;
        w     = 4'h0;
        p     = '0;
        r_old = '0;
        r_new = '0;
        for (int i = 0; i < NCH; i++) begin
            // weight is code plus one eighths
            w = {1'b0, eff_coef} + 4'h1;
            p = PW'(w) * PW'({st_r.alu[i], {FRAC{1'b0}}})
              + PW'(WEIGHT_ONE - w) * PW'(st_r.acc[i]);
            acc_new[i] = st_r.acc[i];
            if (fold_now && i_measurement_enable_1[i]) begin
                if (init_req && !st_r.init_done) begin
                    acc_new[i] = {st_r.alu[i], {FRAC{1'b0}}};
                end else begin
                    acc_new[i] = p[AW+FRAC-1:FRAC];
                end
            end
            r_old      = {1'b0, st_r.acc[i]} + ROUND_HALF;
            r_new      = {1'b0, acc_new[i]} + ROUND_HALF;
            rnd_old[i] = r_old[AW-1:FRAC];
            rnd_new[i] = r_new[AW-1:FRAC];
        end
    end

    // =========================================================================
    // Next state
    always_comb begin
        logic [NCH-1:0][DW-1:0] src;
        logic [SW-1:0]          sum;
        logic [DW-1:0]          vmin;
        logic [DW-1:0]          vmax;
        logic [3:0]             imin;
        logic [3:0]             imax;
        src    = '0;
        sum    = '0;
        vmin   = '1;
        vmax   = '0;
        imin   = 4'h0;
        imax   = 4'h0;
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;

        if (i_smp_valid && i_smp_chan <= BLOCK_CH) begin
            st_nxt.alu[i_smp_chan] = i_calibration_enable ? i_cal_data : i_raw_data;
        end
        if (i_diag_valid) begin
            st_nxt.d1_alu = i_diag1_data;
            st_nxt.d2_alu = i_diag2_data;
        end
        if (i_coef_wr) begin
            st_nxt.coef = i_coef_wdata;
        end

        st_nxt.acc = acc_new;
        if (fold_now && init_req) begin
            st_nxt.init_done = 1'b1;
        end
        if (!init_req) begin
            st_nxt.init_done = 1'b0;
        end

        for (int i = 0; i < NCH; i++) begin
            src[i] = i_alert_source_select ? rnd_new[i] : st_r.alu[i];
        end
        for (int i = 0; i < NCELL; i++) begin
            sum = sum + SW'(src[i]);
            if (src[i] < vmin) begin
                vmin = src[i];
                imin = 4'(i);
            end
            if (src[i] >= vmax) begin
                vmax = src[i];
                imax = 4'(i);
            end
        end

        if (move_now) begin
            for (int i = 0; i < NCH; i++) begin
                st_nxt.res[i] = i_read_filtered_select ? rnd_new[i] : st_r.alu[i];
            end
            st_nxt.diag1 = st_r.d1_alu;
            st_nxt.diag2 = st_r.d2_alu;
            // Only a scan move refreshes derived values; a lone out-of-scan move leaves them alone.
            if (move_scan) begin
                st_nxt.alrt = src;
                st_nxt.sum  = sum;
                st_nxt.ext  = {imax, imin};
                st_nxt.mism = vmax - vmin;
            end
            st_nxt.pend = 1'b0;
        end
        if (i_scan_end && i_double_buffer_enable) begin
            st_nxt.pend = 1'b1;
        end

        // Set wins over clear on both flags.
        if (i_scan_start) begin
            st_nxt.done = 1'b0;
        end
        if (i_scan_end) begin
            st_nxt.done = 1'b1;
        end
        if (i_ready_clear) begin
            st_nxt.ready = 1'b0;
        end
        if (move_now) begin
            st_nxt.ready = 1'b1;
        end

        if (i_rd_en) begin
            st_nxt.rd_valid = 1'b1;
            st_nxt.rd = (i_rd_addr == ADDR_BLOCK) ? st_r.res[BLOCK_CH] : RESULT_RESET;
        end

        if (!i_resetn) begin
            st_nxt      = '0;
            st_nxt.coef = COEF_RESET;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        st_r <= st_nxt;
    end

    // =========================================================================
    // Outputs
    assign o_rd_data               = st_r.rd;
    assign o_rd_valid              = st_r.rd_valid;
    assign o_filter_coefficient    = st_r.coef;
    assign o_cell_result           = st_r.res[NCELL-1:0];
    assign o_block_voltage_result  = st_r.res[BLOCK_CH];
    assign o_alert_data            = st_r.alrt;
    assign o_sum_result            = st_r.sum;
    assign o_extreme_cell_index    = st_r.ext;
    assign o_mismatch_value        = st_r.mism;
    assign o_diag_result_1         = st_r.diag1;
    assign o_diag_result_2         = st_r.diag2;
    assign o_acquisition_done_flag = st_r.done;
    assign o_result_ready_flag     = st_r.ready;

    // =========================================================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_coef_after_reset: assert property (
        $past(!i_resetn) && !$past(i_coef_wr) |-> st_r.coef == COEF_RESET)
        else $error("coefficient not at reset code");

    a_amend_off_hold: assert property (
        !i_filter_amend_enable && !i_balance_active |=> st_r.acc == $past(st_r.acc))
        else $error("accumulators changed with amend off");

    a_single_flags: assert property (
        i_scan_end && !i_double_buffer_enable |=> st_r.ready && st_r.done)
        else $error("single buffer flags not set at scan end");

    a_double_move: assert property (
        i_scan_start && i_double_buffer_enable && st_r.pend |=> st_r.ready && !st_r.pend)
        else $error("double buffer move missing");

    a_diag_raw_copy: assert property (
        move_now |=> st_r.diag1 == $past(st_r.d1_alu) && st_r.diag2 == $past(st_r.d2_alu))
        else $error("diagnostic result not from raw data");

    a_raw_out_move: assert property (
        move_now && !i_read_filtered_select |=> st_r.res[BLOCK_CH] == $past(st_r.alu[BLOCK_CH]))
        else $error("raw output not copied from ALU");

    a_stale_read: assert property (
        move_now && i_read_filtered_select && !amend_eff |=> st_r.res[BLOCK_CH] == $past(rnd_old[BLOCK_CH]))
        else $error("stale accumulator not output");

    // One copy per channel, so a disabled cell is caught wherever it sits.
    for (genvar g = 0; g < NCH; g++) begin : g_off_chk
        a_disabled_chan: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
            !i_measurement_enable_1[g] |=> st_r.acc[g] == $past(st_r.acc[g]))
            else $error("disabled channel filtered");
    end

    a_balance_force: assert property (
        i_balance_active && st_r.coef == COEF_OFF |-> eff_coef == COEF_BALANCE && amend_eff)
        else $error("balancing coefficient not forced");

    a_init_load: assert property (
        fold_now && init_req && !st_r.init_done && i_measurement_enable_1[BLOCK_CH]
        |=> st_r.acc[BLOCK_CH] == {$past(st_r.alu[BLOCK_CH]), 3'h0} && st_r.init_done)
        else $error("init did not load first sample");

    a_oos_keeps_sum: assert property (
        move_oos && !move_scan |=> st_r.sum == $past(st_r.sum) && st_r.ready)
        else $error("out-of-scan move altered sum");

    a_cal_path: assert property (
        i_smp_valid && i_smp_chan == BLOCK_CH && i_calibration_enable |=> st_r.alu[BLOCK_CH] == $past(i_cal_data))
        else $error("calibrated sample not stored");

    a_raw_path: assert property (
        i_smp_valid && i_smp_chan == BLOCK_CH && !i_calibration_enable |=> st_r.alu[BLOCK_CH] == $past(i_raw_data))
        else $error("raw sample not stored");

    // A weight of one must make the accumulator follow the sample exactly.
    a_weight_one: assert property (
        fold_now && eff_coef == COEF_OFF && (!init_req || st_r.init_done) && i_measurement_enable_1[BLOCK_CH]
        |=> st_r.acc[BLOCK_CH] == {$past(st_r.alu[BLOCK_CH]), 3'h0})
        else $error("weight one did not pass sample");

    a_dbl_end_hold: assert property (
        i_scan_end && i_double_buffer_enable && !i_scan_start && !move_oos |=> st_r.res == $past(st_r.res) && st_r.pend)
        else $error("double buffer moved at scan end");

    a_oos_refused: assert property (
        i_move_req && st_r.ready && !move_scan |=> st_r.res == $past(st_r.res))
        else $error("move accepted while results ready");

    a_ready_clear: assert property (
        i_ready_clear && !move_now |=> !st_r.ready)
        else $error("ready flag not cleared");

    a_alert_raw: assert property (
        move_scan && !i_alert_source_select |=> st_r.alrt == $past(st_r.alu))
        else $error("alert data not from raw results");

    a_read_block: assert property (
        i_rd_en && i_rd_addr == ADDR_BLOCK |=> o_rd_valid && o_rd_data == $past(st_r.res[BLOCK_CH]))
        else $error("block result read wrong");

    a_done_clear: assert property (
        i_scan_start && !i_scan_end |=> !st_r.done)
        else $error("done flag not cleared at scan start");
endmodule : mid_filter

// *** sim/tb_top.sv ***
// Self-checking bench for mid_filter: filter arithmetic, result routing, moves and register read.
// Assumes the mid_pkg constants, one 100 MHz clock and inputs driven on the falling edge.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import mid_pkg::*;
    // =========================================================================
    // Stimulus, observed outputs and reference model
    localparam logic [3:0] EV_ST = 4'h8, EV_END = 4'h4, EV_MV = 4'h2, EV_RC = 4'h1;
    logic i_clk_sys = 0, i_resetn = 0, i_smp_valid = 0, i_diag_valid = 0, i_scan_start = 0, i_scan_end = 0;
    logic i_move_req = 0, i_balance_active = 0, i_calibration_enable = 0, i_filter_amend_enable = 0;
    logic i_read_filtered_select = 0, i_alert_source_select = 0, i_scan_filter_init = 0;
    logic i_balance_filter_init = 0, i_double_buffer_enable = 0, i_coef_wr = 0, i_ready_clear = 0, i_rd_en = 0;
    logic [CHW-1:0]           i_smp_chan = '0;
    logic [DW-1:0]            i_raw_data = '0, i_cal_data = '0, i_diag1_data = '0, i_diag2_data = '0;
    logic [NCH-1:0]           i_measurement_enable_1 = '0;
    logic [2:0]               i_coef_wdata = '0;
    logic [ADW-1:0]           i_rd_addr = '0;
    logic [DW-1:0]            o_rd_data, o_block_voltage_result, o_mismatch_value, o_diag_result_1, o_diag_result_2;
    logic                     o_rd_valid, o_acquisition_done_flag, o_result_ready_flag;
    logic [2:0]               o_filter_coefficient;
    logic [NCELL*DW-1:0]      o_cell_result;
    logic [NCH*DW-1:0]        o_alert_data;
    logic [SW-1:0]            o_sum_result, exp_sum;
    logic [7:0]               o_extreme_cell_index;
    logic [AW-1:0]            am [NCH] = '{default: '0};
    logic [DW-1:0]            sm [NCH];
    int                       err_total = 0;
    int                       checks = 0;

    mid_filter dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_smp_valid(i_smp_valid), .i_smp_chan(i_smp_chan),
        .i_raw_data(i_raw_data), .i_cal_data(i_cal_data), .i_diag_valid(i_diag_valid), .i_diag1_data(i_diag1_data),
        .i_diag2_data(i_diag2_data), .i_scan_start(i_scan_start), .i_scan_end(i_scan_end), .i_move_req(i_move_req),
        .i_balance_active(i_balance_active), .i_calibration_enable(i_calibration_enable),
        .i_measurement_enable_1(i_measurement_enable_1), .i_filter_amend_enable(i_filter_amend_enable),
        .i_read_filtered_select(i_read_filtered_select), .i_alert_source_select(i_alert_source_select),
        .i_scan_filter_init(i_scan_filter_init), .i_balance_filter_init(i_balance_filter_init),
        .i_double_buffer_enable(i_double_buffer_enable), .i_coef_wr(i_coef_wr), .i_coef_wdata(i_coef_wdata),
        .i_ready_clear(i_ready_clear), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_filter_coefficient(o_filter_coefficient), .o_cell_result(o_cell_result),
        .o_block_voltage_result(o_block_voltage_result), .o_alert_data(o_alert_data), .o_sum_result(o_sum_result),
        .o_extreme_cell_index(o_extreme_cell_index), .o_mismatch_value(o_mismatch_value),
        .o_diag_result_1(o_diag_result_1), .o_diag_result_2(o_diag_result_2),
        .o_acquisition_done_flag(o_acquisition_done_flag), .o_result_ready_flag(o_result_ready_flag));

    always #5 i_clk_sys = ~i_clk_sys;

    // =========================================================================
    // Access tasks and model arithmetic
    task automatic load(input logic [15:0] base, input logic [15:0] step);
        for (int i = 0; i < NCH; i++) begin
            @(negedge i_clk_sys);
            i_smp_valid = 1'b1;
            i_smp_chan = CHW'(i);
            i_raw_data = base + step * 16'(i);
            i_cal_data = i_raw_data + 16'h0010;
            sm[i] = i_calibration_enable ? i_cal_data : i_raw_data;
        end
        @(negedge i_clk_sys);
        i_smp_valid = 1'b0;
    endtask : load

    // Accumulators keep three fraction bits, so the model works in eighths too.
    task automatic fold(input bit init, input int w);
        for (int i = 0; i < NCH; i++)
            if (i_measurement_enable_1[i])
                am[i] = init ? AW'(sm[i]) << 3 : AW'((w * int'(sm[i]) * 8 + (8 - w) * int'(am[i])) >> 3);
    endtask : fold

    function automatic logic [DW-1:0] rnd(input logic [AW-1:0] a);
        return DW'((int'(a) + 4) >> 3);
    endfunction : rnd

    task automatic ev(input logic [3:0] k);
        @(negedge i_clk_sys);
        {i_scan_start, i_scan_end, i_move_req, i_ready_clear} = k;
        @(negedge i_clk_sys);
        {i_scan_start, i_scan_end, i_move_req, i_ready_clear} = 4'h0;
        @(negedge i_clk_sys);
    endtask : ev

    task automatic rd(input logic [ADW-1:0] a, input logic [DW-1:0] exp);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        i_rd_en = 1'b1;
        i_rd_addr = a;
        @(negedge i_clk_sys);
        i_rd_en = 1'b0;
        while (o_rd_valid !== 1'b1 && n < 3) begin
            @(negedge i_clk_sys);
            n++;
        end
        `CHK(o_rd_valid, 1'b1)
        `CHK(o_rd_data, exp)
    endtask : rd

    task automatic coef(input logic [2:0] c);
        @(negedge i_clk_sys);
        i_coef_wr = 1'b1;
        i_coef_wdata = c;
        @(negedge i_clk_sys);
        i_coef_wr = 1'b0;
        `CHK(o_filter_coefficient, c)
    endtask : coef

    task automatic chk_out(input bit f);
        for (int i = 0; i < NCELL; i++)
            `CHK(o_cell_result[DW*i +: DW], f ? rnd(am[i]) : sm[i])
        `CHK(o_block_voltage_result, f ? rnd(am[NCH-1]) : sm[NCH-1])
    endtask : chk_out

    // Ties resolve to the lowest index for the minimum and the highest for the maximum.
    task automatic chk_alert(input bit f);
        logic [DW-1:0] v [NCH];
        int mx, mn;
        exp_sum = '0;
        mx = 0;
        mn = 0;
        for (int i = 0; i < NCH; i++) begin
            v[i] = f ? rnd(am[i]) : sm[i];
            `CHK(o_alert_data[DW*i +: DW], v[i])
        end
        for (int i = 0; i < NCELL; i++) begin
            exp_sum += SW'(v[i]);
            if (v[i] >= v[mx]) mx = i;
            if (v[i] < v[mn]) mn = i;
        end
        `CHK(o_sum_result, exp_sum)
        `CHK(o_extreme_cell_index, {4'(mx), 4'(mn)})
        `CHK(o_mismatch_value, v[mx] - v[mn])
    endtask : chk_alert

    task automatic close_out();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // =========================================================================
    // Test sequence
    initial begin
        repeat (3) @(negedge i_clk_sys);
        i_resetn = 1'b1;
        `CHK(o_filter_coefficient, COEF_RESET)
        `CHK({o_acquisition_done_flag, o_result_ready_flag}, 2'b00)
        rd(ADDR_BLOCK, RESULT_RESET);
        // Cell 3 stays out of the filter so its memory must never move.
        i_measurement_enable_1 = 15'h7FF7;
        i_filter_amend_enable = 1'b1;
        i_read_filtered_select = 1'b1;
        load(16'h0080, 16'h0010); ev(EV_END); fold(0, 3);
        chk_out(1);
        chk_alert(0);
        `CHK({o_acquisition_done_flag, o_result_ready_flag}, 2'b11)
        i_alert_source_select = 1'b1;
        i_calibration_enable = 1'b1;
        load(16'h0100, 16'h0020); ev(EV_END); fold(0, 3);
        chk_out(1);
        chk_alert(1);
        i_calibration_enable = 1'b0;
        i_alert_source_select = 1'b0;
        for (int c = 0; c < 8; c++) begin
            coef(3'(c));
            i_scan_filter_init = 1'b1;
            load(16'h0100, 16'h0000); ev(EV_END); fold(1, c + 1);
            chk_out(1);
            load(16'h0300, 16'h0008); ev(EV_END); fold(0, c + 1);
            chk_out(1);
            i_scan_filter_init = 1'b0;
        end
        i_filter_amend_enable = 1'b0;
        load(16'h0555, 16'h0001); ev(EV_END);
        chk_out(1);
        i_read_filtered_select = 1'b0;
        load(16'h0444, 16'h0001); ev(EV_END);
        chk_out(0);
        // Code 7 is still programmed, so balancing must fall back to one eighth.
        i_balance_active = 1'b1;
        i_read_filtered_select = 1'b1;
        load(16'h0200, 16'h0002); ev(EV_END); fold(0, 1);
        chk_out(1);
        i_balance_filter_init = 1'b1;
        load(16'h0600, 16'h0002); ev(EV_END); fold(1, 1);
        chk_out(1);
        i_balance_filter_init = 1'b0;
        i_balance_active = 1'b0;
        coef(3'h2);
        i_filter_amend_enable = 1'b1;
        i_read_filtered_select = 1'b0;
        i_alert_source_select = 1'b1;
        @(negedge i_clk_sys);
        i_diag_valid = 1'b1;
        i_diag1_data = 16'h0ABC;
        i_diag2_data = 16'h0DEF;
        @(negedge i_clk_sys);
        i_diag_valid = 1'b0;
        load(16'h0300, 16'h0004); ev(EV_END); fold(0, 3);
        chk_out(0);
        chk_alert(1);
        `CHK(o_diag_result_1, 16'h0ABC)
        `CHK(o_diag_result_2, 16'h0DEF)
        i_read_filtered_select = 1'b1;
        load(16'h0700, 16'h0003); ev(EV_RC);
        `CHK(o_result_ready_flag, 1'b0)
        ev(EV_MV); fold(0, 3);
        chk_out(1);
        `CHK(o_result_ready_flag, 1'b1)
        `CHK(o_sum_result, exp_sum)
        load(16'h0900, 16'h0003); ev(EV_MV);
        chk_out(1);
        i_double_buffer_enable = 1'b1;
        ev(EV_RC); ev(EV_ST);
        `CHK(o_acquisition_done_flag, 1'b0)
        load(16'h0A00, 16'h0005); ev(EV_END);
        `CHK({o_acquisition_done_flag, o_result_ready_flag}, 2'b10)
        chk_out(1);
        ev(EV_ST); fold(0, 3);
        chk_out(1);
        `CHK({o_acquisition_done_flag, o_result_ready_flag}, 2'b01)
        rd(ADDR_BLOCK, rnd(am[NCH-1]));
        rd(8'h54, 16'h0000);
        close_out();
    end

    // A hang far beyond the roughly 540 cycles of the sequence ends the run.
    initial begin
        #200_000;
        err_total++;
        close_out();
    end
endmodule : tb_top
